/* File: core/cell_threshold_alert_status.sv */
/*
  Alert status bank: compares stored acquisition results against limits,
  keeps per-channel alert flags, serves them read-only over a plain port,
  and raises a masked interrupt on newly set flags.
  Assumes results are written before the acquisition-complete strobe and are
  not rewritten during the 28-cycle scan that follows it.
*/
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps
`include "alert_defines.svh"

module cell_threshold_alert_status (
  input  wire logic                mclk_i,
  input  wire logic                rst_i,
  // Register port
  input  wire logic [`ADDR_W-1:0]  addr_i,
  input  wire logic [`DATA_W-1:0]  wr_data_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output logic [`DATA_W-1:0]       rd_data_o,
  // Acquisition results and strobe
  input  wire logic                result_wr_i,
  input  wire logic [`IDX_W-1:0]   result_idx_i,
  input  wire logic [`RES_W-1:0]   result_data_i,
  input  wire logic                acq_done_i,
  // Limits from the threshold and enable registers
  input  wire logic [`RES_W-1:0]   over_limit_setting_i,
  input  wire logic [`RES_W-1:0]   under_limit_setting_i,
  input  wire logic [`RES_W-1:0]   cold_limit_i,
  input  wire logic [`RES_W-1:0]   hot_limit_i,
  input  wire logic [`NCELL-1:0]   cell_over_check_enable_i,
  input  wire logic [`NCELL-1:0]   cell_under_check_enable_i,
  input  wire logic [2:0]          balance_diag_threshold_sel_i,
  // Status
  output logic                     balance_alert_any_o,
  output logic                     scan_busy_o,
  output logic                     irq_o
);

  alert_pkg::scan_state_e state_reg;
  alert_pkg::idx_t        scan_idx_reg;
  alert_pkg::idx_t        chk_idx_reg;
  logic                   chk_vld_reg;
  logic [`RES_W-1:0]      rd_res;

  logic [`NCELL-1:0]      ov_stage_reg;
  logic [`NCELL-1:0]      uv_stage_reg;
  logic [1:0]             cold_stage_reg;
  logic [1:0]             hot_stage_reg;
  logic [`NBAL-1:0]       bal_stage_reg;

  logic [`NCELL-1:0]      cell_over_flags_reg;
  logic [`NCELL-1:0]      cell_under_flags_reg;
  logic [1:0]             therm_cold_flags_reg;
  logic [1:0]             therm_hot_flags_reg;
  logic [`NBAL-1:0]       balance_switch_diag_flags_reg;

  logic [`IRQ_W-1:0]      irq_status_reg;
  logic [`IRQ_W-1:0]      irq_mask_reg;
  logic [`IRQ_W-1:0]      irq_event;
  logic [`DATA_W-1:0]     rd_data_next;

  // Threshold table lookup for balance diagnostics
  function automatic logic [`RES_W-1:0] bal_threshold(input logic [2:0] sel);
    logic [`RES_W-1:0] t;
    t = `BAL_THR_0;
    unique case (sel)
      3'h0: t = `BAL_THR_0;
      3'h1: t = `BAL_THR_1;
      3'h2: t = `BAL_THR_2;
      3'h3: t = `BAL_THR_3;
      3'h4: t = `BAL_THR_4;
      3'h5: t = `BAL_THR_5;
      3'h6: t = `BAL_THR_6;
      3'h7: t = `BAL_THR_7;
    endcase
    return t;
  endfunction : bal_threshold

  // Register images, also used for read-back
  function automatic logic [`DATA_W-1:0] cell_image(input logic [1:0] therm, input logic [`NCELL-1:0] cells);
    return {2'b00, therm, cells};
  endfunction : cell_image

  result_store u_store (
    .mclk_i    (mclk_i),
    .wr_en_i   (result_wr_i),
    .wr_addr_i (result_idx_i),
    .wr_data_i (result_data_i),
    .rd_addr_i (scan_idx_reg),
    .rd_data_o (rd_res)
  );

  // Scan sequencer; a strobe arriving mid-scan is ignored
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg    <= alert_pkg::ST_IDLE;
      scan_idx_reg <= `IDX_CELL_BASE;
    end else begin
      unique case (state_reg)
        alert_pkg::ST_IDLE: begin
          scan_idx_reg <= `IDX_CELL_BASE;
          if (acq_done_i) begin
            state_reg <= alert_pkg::ST_SCAN;
          end
        end
        alert_pkg::ST_SCAN: begin
          if (scan_idx_reg == `IDX_LAST) begin
            state_reg <= alert_pkg::ST_DRAIN;
          end else begin
            scan_idx_reg <= scan_idx_reg + 5'h01;
          end
        end
        alert_pkg::ST_DRAIN: begin
          state_reg <= alert_pkg::ST_COMMIT;
        end
        alert_pkg::ST_COMMIT: begin
          state_reg <= alert_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Read data for chk_idx is valid one cycle after the address
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      chk_vld_reg <= 1'b0;
      chk_idx_reg <= `IDX_CELL_BASE;
    end else begin
      chk_vld_reg <= (state_reg == alert_pkg::ST_SCAN);
      chk_idx_reg <= scan_idx_reg;
    end
  end

  // Comparisons into staging, so every flag changes on the same edge
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ov_stage_reg   <= '0;
      uv_stage_reg   <= '0;
      cold_stage_reg <= '0;
      hot_stage_reg  <= '0;
      bal_stage_reg  <= '0;
    end else if (state_reg == alert_pkg::ST_IDLE && acq_done_i) begin
      ov_stage_reg   <= '0;
      uv_stage_reg   <= '0;
      cold_stage_reg <= '0;
      hot_stage_reg  <= '0;
      bal_stage_reg  <= '0;
    end else if (chk_vld_reg) begin
      if (chk_idx_reg < `IDX_AIN_BASE) begin
        ov_stage_reg[chk_idx_reg[3:0]] <= (rd_res > over_limit_setting_i)
                                          && cell_over_check_enable_i[chk_idx_reg[3:0]];
        uv_stage_reg[chk_idx_reg[3:0]] <= (rd_res < under_limit_setting_i)
                                          && cell_under_check_enable_i[chk_idx_reg[3:0]];
      end else if (chk_idx_reg < `IDX_BAL_BASE) begin
        cold_stage_reg[chk_idx_reg[0]] <= (rd_res > cold_limit_i);
        hot_stage_reg[chk_idx_reg[0]]  <= (rd_res < hot_limit_i);
      end else begin
        bal_stage_reg[4'(chk_idx_reg - `IDX_BAL_BASE)] <=
          (rd_res > bal_threshold(balance_diag_threshold_sel_i));
      end
    end
  end

  // Flags change only here; the register port has no path to them
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cell_over_flags_reg           <= `RST_CELL_FLAGS;
      cell_under_flags_reg          <= `RST_CELL_FLAGS;
      therm_cold_flags_reg          <= `RST_THERM;
      therm_hot_flags_reg           <= `RST_THERM;
      balance_switch_diag_flags_reg <= `RST_CELL_FLAGS;
    end else if (state_reg == alert_pkg::ST_COMMIT) begin
      cell_over_flags_reg           <= ov_stage_reg;
      cell_under_flags_reg          <= uv_stage_reg;
      therm_cold_flags_reg          <= cold_stage_reg;
      therm_hot_flags_reg           <= hot_stage_reg;
      balance_switch_diag_flags_reg <= bal_stage_reg;
    end
  end

  // Events are flags that rise at commit, not flags that persist
  always_comb begin
    irq_event = '0;
    if (state_reg == alert_pkg::ST_COMMIT) begin
      irq_event[`IRQ_CELL_OVER]  = |(ov_stage_reg & ~cell_over_flags_reg);
      irq_event[`IRQ_CELL_UNDER] = |(uv_stage_reg & ~cell_under_flags_reg);
      irq_event[`IRQ_THERM]      = |(cold_stage_reg & ~therm_cold_flags_reg)
                                   | |(hot_stage_reg & ~therm_hot_flags_reg);
      irq_event[`IRQ_BAL]        = |(bal_stage_reg & ~balance_switch_diag_flags_reg);
    end
  end

  // Write-one-to-clear; a simultaneous event keeps its bit set
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_status_reg <= `RST_IRQ;
    end else begin
      irq_status_reg <= (irq_status_reg
                         & ~((wr_i && addr_i == `REG_IRQ_STATUS) ? wr_data_i[`IRQ_W-1:0] : `RST_IRQ))
                        | irq_event;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_mask_reg <= `RST_IRQ;
    end else if (wr_i && addr_i == `REG_IRQ_MASK) begin
      irq_mask_reg <= wr_data_i[`IRQ_W-1:0];
    end
  end

  // Read decode; unmapped offsets read zero
  always_comb begin
    rd_data_next = '0;
    unique case (addr_i)
      `REG_FAULT_DIAG1: rd_data_next[`BIT_BAL_ANY] = |balance_switch_diag_flags_reg;
      `REG_CELL_OVER:   rd_data_next = cell_image(therm_cold_flags_reg, cell_over_flags_reg);
      `REG_CELL_UNDER:  rd_data_next = cell_image(therm_hot_flags_reg, cell_under_flags_reg);
      `REG_BAL_DIAG:    rd_data_next = {4'h0, balance_switch_diag_flags_reg};
      `REG_IRQ_STATUS:  rd_data_next = {12'h000, irq_status_reg};
      `REG_IRQ_MASK:    rd_data_next = {12'h000, irq_mask_reg};
      default:          rd_data_next = '0;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= rd_i ? rd_data_next : '0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      balance_alert_any_o <= 1'b0;
      scan_busy_o         <= 1'b0;
      irq_o               <= 1'b0;
    end else begin
      balance_alert_any_o <= |balance_switch_diag_flags_reg;
      scan_busy_o         <= (state_reg != alert_pkg::ST_IDLE);
      irq_o               <= |(irq_status_reg & irq_mask_reg);
    end
  end

endmodule : cell_threshold_alert_status

/* File: core/alert_defines.svh */
/*
  Offsets, field positions, reset values and counts of the alert status bank.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef ALERT_DEFINES_SVH
`define ALERT_DEFINES_SVH

`define ADDR_W            8
`define DATA_W            16
`define RES_W             16
`define IDX_W             5
`define NCELL             12
`define NBAL              12

`define REG_FAULT_DIAG1   8'h03
`define REG_CELL_OVER     8'h05
`define REG_CELL_UNDER    8'h07
`define REG_BAL_DIAG      8'h08
`define REG_IRQ_STATUS    8'h20
`define REG_IRQ_MASK      8'h21

`define BIT_THERM1        13
`define BIT_THERM0        12
`define BIT_BAL_ANY       5
`define IRQ_W             4
`define IRQ_CELL_OVER     0
`define IRQ_CELL_UNDER    1
`define IRQ_THERM         2
`define IRQ_BAL           3

`define RST_FLAGS         16'h0000
`define RST_CELL_FLAGS    12'h000
`define RST_THERM         2'h0
`define RST_IRQ           4'h0

`define IDX_CELL_BASE     5'h00
`define IDX_AIN_BASE      5'h0c
`define IDX_BAL_BASE      5'h0e
`define IDX_LAST          5'h19

// Balance diagnostic threshold table, plain defaults
`define BAL_THR_0         16'h0100
`define BAL_THR_1         16'h0200
`define BAL_THR_2         16'h0300
`define BAL_THR_3         16'h0400
`define BAL_THR_4         16'h0600
`define BAL_THR_5         16'h0800
`define BAL_THR_6         16'h0a00
`define BAL_THR_7         16'h0c00

`endif

/* File: core/alert_pkg.sv */
/*
  Types of the alert status bank.
  Assumes alert_defines.svh is on the include path.
*/
`include "alert_defines.svh"

package alert_pkg;

  typedef logic [`DATA_W-1:0] word_t;
  typedef logic [`IDX_W-1:0]  idx_t;

  // Gray sequence idle -> scan -> drain -> commit -> idle
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SCAN   = 2'b01,
    ST_DRAIN  = 2'b11,
    ST_COMMIT = 2'b10
  } scan_state_e;

endpackage : alert_pkg

/* File: core/result_store.sv */
/*
  Storage for one acquisition worth of results, 32 words.
  Assumes one clock; read data is registered, one cycle after the address.
*/
`timescale 1ns/100ps
`include "alert_defines.svh"

module result_store (
  input  wire logic              mclk_i,
  input  wire logic              wr_en_i,
  input  wire alert_pkg::idx_t   wr_addr_i,
  input  wire alert_pkg::word_t  wr_data_i,
  input  wire alert_pkg::idx_t   rd_addr_i,
  output logic [`RES_W-1:0]      rd_data_o
);

  logic [`RES_W-1:0] mem [0:(1<<`IDX_W)-1];

  always_ff @(posedge mclk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    rd_data_o <= mem[rd_addr_i];
  end

endmodule : result_store

/* File: sim/cell_threshold_alert_status_monitor.sv */
/*
  Port checker of the alert status bank.
  Assumes one clock and the bind below onto the design's top module.
*/
`timescale 1ns/100ps
`include "alert_defines.svh"

module alert_bank_checker (
  input  wire logic                mclk_i,
  input  wire logic                rst_i,
  input  wire logic [`ADDR_W-1:0]  addr_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  input  wire logic                acq_done_i,
  input  wire logic [`DATA_W-1:0]  rd_data_o,
  input  wire logic                balance_alert_any_o,
  input  wire logic                scan_busy_o,
  input  wire logic                irq_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  a_read_idle_zero: assert property (!$past(rd_i) |-> rd_data_o == 16'h0000)
    else $error("read data not zero outside the answer cycle");
  a_cell_top_zero: assert property ($past(rd_i) && $past(addr_i) inside {8'h05, 8'h07} |-> rd_data_o[15:14] == 2'b00)
    else $error("top bits of a cell alert register set");
  a_bal_top_zero: assert property ($past(rd_i) && $past(addr_i) == 8'h08 |-> rd_data_o[15:12] == 4'h0)
    else $error("unused bits of the balance register set");
  a_fault_only_bit5: assert property ($past(rd_i) && $past(addr_i) == 8'h03 |-> (rd_data_o & 16'hffdf) == 16'h0000)
    else $error("fault status register shows more than the summary bit");
  a_acq_starts_scan: assert property (acq_done_i && !scan_busy_o |-> ##[1:2] scan_busy_o)
    else $error("accepted acquisition did not start a scan");
  a_scan_min_len: assert property ($rose(scan_busy_o) |-> scan_busy_o[*8])
    else $error("scan ended too early");
  a_scan_ends: assert property ($rose(scan_busy_o) |-> ##[20:32] !scan_busy_o)
    else $error("scan did not finish in time");
  a_summary_on_commit: assert property ($changed(balance_alert_any_o) |-> $past(scan_busy_o) || $past(scan_busy_o, 2))
    else $error("balance summary moved outside an acquisition commit");
  a_irq_rise_cause: assert property ($rose(irq_o) |-> $past(scan_busy_o) || $past(scan_busy_o, 2) || $past(wr_i) || $past(wr_i, 2))
    else $error("interrupt rose without a commit or a write");
  a_irq_fall_cause: assert property ($fell(irq_o) |-> $past(wr_i) || $past(wr_i, 2))
    else $error("interrupt fell without a write");
endmodule : alert_bank_checker

bind cell_threshold_alert_status alert_bank_checker u_checker (.mclk_i, .rst_i, .addr_i, .wr_i, .rd_i, .acq_done_i,
  .rd_data_o, .balance_alert_any_o, .scan_busy_o, .irq_o);

/* File: sim/cell_threshold_alert_status_bench.sv */
/*
  Self-checking bench of the alert status bank.
  Assumes the design, package and checker are compiled before it.
*/
`timescale 1ns/100ps
`include "alert_defines.svh"

module cell_threshold_alert_status_bench;
  logic        mclk_i, rst_i, wr_i, rd_i, result_wr_i, acq_done_i;
  logic        balance_alert_any_o, scan_busy_o, irq_o;
  logic [7:0]  addr_i;
  logic [4:0]  result_idx_i;
  logic [2:0]  balance_diag_threshold_sel_i;
  logic [11:0] cell_over_check_enable_i, cell_under_check_enable_i;
  logic [15:0] wr_data_i, result_data_i, rd_data_o;
  logic [15:0] over_limit_setting_i, under_limit_setting_i, cold_limit_i, hot_limit_i;
  logic [15:0] thr [8] = '{`BAL_THR_0, `BAL_THR_1, `BAL_THR_2, `BAL_THR_3,
                           `BAL_THR_4, `BAL_THR_5, `BAL_THR_6, `BAL_THR_7};
  logic [7:0]  regs [5] = '{8'h03, 8'h05, 8'h06, 8'h07, 8'h08};
  int          miscompares, total_checks, cycles;

  cell_threshold_alert_status dut (.mclk_i, .rst_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o, .result_wr_i,
    .result_idx_i, .result_data_i, .acq_done_i, .over_limit_setting_i, .under_limit_setting_i, .cold_limit_i,
    .hot_limit_i, .cell_over_check_enable_i, .cell_under_check_enable_i, .balance_diag_threshold_sel_i,
    .balance_alert_any_o, .scan_busy_o, .irq_o);

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // Run takes under 1000 cycles; generous ceiling
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // Each access leaves one idle edge so no strobe is driven twice in a step
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    addr_i    <= a;
    wr_data_i <= d;
    wr_i      <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 chk(rd_data_o, e);
    @(posedge mclk_i);
  endtask : rd

  task automatic store(input int i, input logic [15:0] v);
    result_idx_i  <= i[4:0];
    result_data_i <= v;
    result_wr_i   <= 1'b1;
    @(posedge mclk_i);
    result_wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask : store

  // Scan plus commit is 28 edges after the strobe is taken
  task automatic acq();
    acq_done_i <= 1'b1;
    @(posedge mclk_i);
    acq_done_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    chk({15'h0000, scan_busy_o}, 16'h0001);
    repeat (30) @(posedge mclk_i);
    chk({15'h0000, scan_busy_o}, 16'h0000);
  endtask : acq

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  initial begin
    rst_i                        = 1'b1;
    wr_i                         = 1'b0;
    rd_i                         = 1'b0;
    result_wr_i                  = 1'b0;
    acq_done_i                   = 1'b0;
    addr_i                       = 8'h00;
    wr_data_i                    = 16'h0000;
    result_idx_i                 = 5'h00;
    result_data_i                = 16'h0000;
    over_limit_setting_i         = 16'h0800;
    under_limit_setting_i        = 16'h0400;
    cold_limit_i                 = 16'h0900;
    hot_limit_i                  = 16'h0300;
    cell_over_check_enable_i     = 12'hff7;
    cell_under_check_enable_i    = 12'hfbf;
    balance_diag_threshold_sel_i = 3'd2;
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    foreach (regs[k]) rd(regs[k], 16'h0000);
    // Cells 1-4 over, 5-8 under, 4 and 7 disabled, 9 and 10 sit on the limits
    for (int i = 0; i < 12; i++) store(i, (i < 4) ? 16'h0801 : (i < 8) ? 16'h03ff : (i == 8) ? 16'h0800 :
                                          (i == 9) ? 16'h0400 : 16'h0600);
    store(12, 16'h0901);
    store(13, 16'h02ff);
    for (int i = 14; i < 26; i++) store(i, 16'h0000);
    acq();
    rd(8'h05, 16'h1007);
    rd(8'h07, 16'h20b0);
    chk({15'h0000, irq_o}, 16'h0000);
    rd(8'h20, 16'h0007);
    foreach (regs[k]) wr(regs[k], 16'hffff);
    rd(8'h05, 16'h1007);
    rd(8'h07, 16'h20b0);
    rd(8'h08, 16'h0000);
    wr(8'h21, 16'h0002);
    rd(8'h21, 16'h0002);
    chk({15'h0000, irq_o}, 16'h0001);
    wr(8'h20, 16'h0002);
    rd(8'h20, 16'h0005);
    chk({15'h0000, irq_o}, 16'h0000);
    // Every threshold select; values equal to the threshold must not flag
    for (int s = 0; s < 8; s++) begin
      balance_diag_threshold_sel_i <= s[2:0];
      for (int j = 0; j < 12; j++) store(14 + j, thr[s] + ((j == s || j == s + 4) ? 16'h0001 : 16'h0000));
      acq();
      rd(8'h08, 16'h0011 << s);
      rd(8'h03, 16'h0020);
      chk({15'h0000, balance_alert_any_o}, 16'h0001);
    end
    for (int i = 0; i < 26; i++) store(i, (i < 12) ? 16'h0600 : (i == 12) ? 16'h02ff : (i == 13) ? 16'h0901 : 16'h0000);
    acq();
    rd(8'h05, 16'h2000);
    rd(8'h07, 16'h1000);
    rd(8'h08, 16'h0000);
    rd(8'h03, 16'h0000);
    chk({15'h0000, balance_alert_any_o}, 16'h0000);
    finish_test();
  end
endmodule : cell_threshold_alert_status_bench
